/* rtl/pioci_pkg.sv */
package pioci_pkg;
	// ==========================================
	// Geometry
	localparam int unsigned NUM_LINES = 32;
	localparam int unsigned ADDR_W = 8;
	// ==========================================
	// Register offsets
	localparam logic [7:0] OFF_LINE_CTRL_ENABLE = 8'h00;
	localparam logic [7:0] OFF_LINE_CTRL_DISABLE = 8'h04;
	localparam logic [7:0] OFF_LINE_CTRL_STATUS = 8'h08;
	localparam logic [7:0] OFF_DRIVE_ENABLE = 8'h10;
	localparam logic [7:0] OFF_DRIVE_DISABLE = 8'h14;
	localparam logic [7:0] OFF_DRIVE_STATUS = 8'h18;
	localparam logic [7:0] OFF_GLITCH_FILTER_ENABLE = 8'h20;
	localparam logic [7:0] OFF_GLITCH_FILTER_DISABLE = 8'h24;
	localparam logic [7:0] OFF_GLITCH_FILTER_STATUS = 8'h28;
	localparam logic [7:0] OFF_OUT_LEVEL_SET = 8'h30;
	localparam logic [7:0] OFF_OUT_LEVEL_CLEAR = 8'h34;
	localparam logic [7:0] OFF_OUT_LEVEL_STATUS = 8'h38;
	localparam logic [7:0] OFF_PIN_LEVEL_STATUS = 8'h3c;
	localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE = 8'h40;
	localparam logic [7:0] OFF_CHANGE_IRQ_DISABLE = 8'h44;
	localparam logic [7:0] OFF_CHANGE_IRQ_MASK = 8'h48;
	localparam logic [7:0] OFF_CHANGE_IRQ_STATUS = 8'h4c;
	localparam logic [7:0] OFF_OPEN_DRAIN_ENABLE = 8'h50;
	localparam logic [7:0] OFF_OPEN_DRAIN_DISABLE = 8'h54;
	localparam logic [7:0] OFF_OPEN_DRAIN_STATUS = 8'h58;
	localparam logic [7:0] OFF_PULLUP_DISABLE = 8'h60;
	localparam logic [7:0] OFF_PULLUP_ENABLE = 8'h64;
	localparam logic [7:0] OFF_PULLUP_STATUS = 8'h68;
	localparam logic [7:0] OFF_PERIPH_A_SELECT = 8'h70;
	localparam logic [7:0] OFF_PERIPH_B_SELECT = 8'h74;
	localparam logic [7:0] OFF_PERIPH_SELECT_STATUS = 8'h78;
	localparam logic [7:0] OFF_DIRECT_WRITE_ENABLE = 8'ha0;
	localparam logic [7:0] OFF_DIRECT_WRITE_DISABLE = 8'ha4;
	localparam logic [7:0] OFF_DIRECT_WRITE_STATUS = 8'ha8;
	// ==========================================
	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_LINE_CTRL_DEFAULT = 32'hFFFF_FFFF;
	localparam logic [31:0] IMPL_DEFAULT = 32'hFFFF_FFFF;
	localparam logic [31:0] MUXED_DEFAULT = 32'hFFFF_FFFF;
endpackage : pioci_pkg

/* rtl/pioci_top.sv */
// Function
// - Enable/disable writes set/clear irq mask bits
// - Change means two consecutive samples differ
// - Detection works in every line configuration
// - Change sets status regardless of mask
// - Line interrupts only when status and mask
// - OR all line requests into one interrupt
// - Status read clears all bits except lines changing in that cycle
// - Registers 32 bits, bit n is line n
// - Unimplemented lines: writes ignored, read zero
// - Non-multiplexed lines always report controller-owned
// - Direct write only where direct-write mask set
// - Pin level shows live sampled levels
// - Status resets to zero, may set soon
// - A-select clears, B-select sets select bit
// - Ownership reset value is integration parameter
// - Pin level after reset shows real levels
// - Direct write updates enabled outputs at once
// - Filter feeds readback and detection only
// - Ownership one is controller, zero peripheral
// - Pull-ups on after reset, status zero
`timescale 1ns/1ps
module pioci_top #(
	parameter logic [31:0] IMPL_LINES = pioci_pkg::IMPL_DEFAULT,
	parameter logic [31:0] MUXED_LINES = pioci_pkg::MUXED_DEFAULT,
	parameter logic [31:0] LINE_CTRL_RESET = pioci_pkg::RST_LINE_CTRL_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [31:0] pad_in,
	input wire logic [31:0] periph_a_out,
	input wire logic [31:0] periph_a_oe,
	input wire logic [31:0] periph_b_out,
	input wire logic [31:0] periph_b_oe,
	output logic [31:0] pad_out,
	output logic [31:0] pad_oe,
	output logic [31:0] pullup_on,
	output logic [31:0] periph_in,
	output logic change_irq
);
	// ==========================================
	// Configuration state
	logic [31:0] own_q, own_d;
	logic [31:0] drv_q, drv_d;
	logic [31:0] filt_q, filt_d;
	logic [31:0] lvl_q, lvl_d;
	logic [31:0] mask_q, mask_d;
	logic [31:0] isr_q, isr_d;
	logic [31:0] od_q, od_d;
	logic [31:0] pud_q, pud_d;
	logic [31:0] absel_q, absel_d;
	logic [31:0] dwe_q, dwe_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] wmask;
	logic [31:0] pull_q;

	// Bit n of every register belongs to line n
	assign wmask = reg_wdata & IMPL_LINES;

	function automatic logic [31:0] setclr(input logic [31:0] cur, input logic set_en,
		input logic clr_en, input logic [31:0] bits);
		logic [31:0] r;
		r = cur;
		if (set_en) begin
			r = r | bits;
		end
		if (clr_en) begin
			r = r & ~bits;
		end
		return r;
	endfunction : setclr

	// ==========================================
	// Input sampling
	logic [31:0] sync1_q, sync2_q, samp_q, prev_q, pin_q;
	logic samp_valid_q;

	// Half-cycle filter not modelled; filtered lines need one stable extra sample
	always_ff @(posedge sys_clk) begin
		sync1_q <= pad_in;
		sync2_q <= sync1_q;
		samp_q <= sync2_q;
		// Filtered line keeps previous level until the two samples agree on all 32 lines
		pin_q <= (filt_q & ((sync2_q == samp_q) ? sync2_q : pin_q)) | (~filt_q & sync2_q);
		prev_q <= pin_q;
		if (!rst_n) begin
			samp_valid_q <= 1'b0;
		end else begin
			samp_valid_q <= 1'b1;
		end
	end

	logic [31:0] change;
	// Suppress spurious change on first samples after reset
	assign change = samp_valid_q ? ((pin_q ^ prev_q) & IMPL_LINES) : 32'h0000_0000;

	// ==========================================
	// Register writes and read
	always_comb begin
		own_d = own_q;
		drv_d = drv_q;
		filt_d = filt_q;
		lvl_d = lvl_q;
		mask_d = mask_q;
		od_d = od_q;
		pud_d = pud_q;
		absel_d = absel_q;
		dwe_d = dwe_q;
		rdata_d = pioci_pkg::RST_ZERO;
		if (reg_wr) begin
			unique case (reg_addr)
				pioci_pkg::OFF_LINE_CTRL_ENABLE: own_d = own_q | (wmask & MUXED_LINES);
				pioci_pkg::OFF_LINE_CTRL_DISABLE: own_d = own_q & ~(wmask & MUXED_LINES);
				pioci_pkg::OFF_DRIVE_ENABLE: drv_d = setclr(drv_q, 1'b1, 1'b0, wmask);
				pioci_pkg::OFF_DRIVE_DISABLE: drv_d = setclr(drv_q, 1'b0, 1'b1, wmask);
				pioci_pkg::OFF_GLITCH_FILTER_ENABLE: filt_d = setclr(filt_q, 1'b1, 1'b0, wmask);
				pioci_pkg::OFF_GLITCH_FILTER_DISABLE: filt_d = setclr(filt_q, 1'b0, 1'b1, wmask);
				pioci_pkg::OFF_OUT_LEVEL_SET: lvl_d = setclr(lvl_q, 1'b1, 1'b0, wmask);
				pioci_pkg::OFF_OUT_LEVEL_CLEAR: lvl_d = setclr(lvl_q, 1'b0, 1'b1, wmask);
				pioci_pkg::OFF_OUT_LEVEL_STATUS: lvl_d = (lvl_q & ~(dwe_q & IMPL_LINES))
					| (reg_wdata & dwe_q & IMPL_LINES);
				pioci_pkg::OFF_CHANGE_IRQ_ENABLE: mask_d = setclr(mask_q, 1'b1, 1'b0, wmask);
				pioci_pkg::OFF_CHANGE_IRQ_DISABLE: mask_d = setclr(mask_q, 1'b0, 1'b1, wmask);
				pioci_pkg::OFF_OPEN_DRAIN_ENABLE: od_d = setclr(od_q, 1'b1, 1'b0, wmask);
				pioci_pkg::OFF_OPEN_DRAIN_DISABLE: od_d = setclr(od_q, 1'b0, 1'b1, wmask);
				pioci_pkg::OFF_PULLUP_DISABLE: pud_d = setclr(pud_q, 1'b1, 1'b0, wmask);
				pioci_pkg::OFF_PULLUP_ENABLE: pud_d = setclr(pud_q, 1'b0, 1'b1, wmask);
				pioci_pkg::OFF_PERIPH_A_SELECT: absel_d = setclr(absel_q, 1'b0, 1'b1, wmask);
				pioci_pkg::OFF_PERIPH_B_SELECT: absel_d = setclr(absel_q, 1'b1, 1'b0, wmask);
				pioci_pkg::OFF_DIRECT_WRITE_ENABLE: dwe_d = setclr(dwe_q, 1'b1, 1'b0, wmask);
				pioci_pkg::OFF_DIRECT_WRITE_DISABLE: dwe_d = setclr(dwe_q, 1'b0, 1'b1, wmask);
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				pioci_pkg::OFF_LINE_CTRL_STATUS: rdata_d = (own_q | ~MUXED_LINES) & IMPL_LINES;
				pioci_pkg::OFF_DRIVE_STATUS: rdata_d = drv_q;
				pioci_pkg::OFF_GLITCH_FILTER_STATUS: rdata_d = filt_q;
				pioci_pkg::OFF_OUT_LEVEL_STATUS: rdata_d = lvl_q;
				pioci_pkg::OFF_PIN_LEVEL_STATUS: rdata_d = pin_q & IMPL_LINES;
				pioci_pkg::OFF_CHANGE_IRQ_MASK: rdata_d = mask_q;
				pioci_pkg::OFF_CHANGE_IRQ_STATUS: rdata_d = isr_q;
				pioci_pkg::OFF_OPEN_DRAIN_STATUS: rdata_d = od_q;
				pioci_pkg::OFF_PULLUP_STATUS: rdata_d = pud_q;
				pioci_pkg::OFF_PERIPH_SELECT_STATUS: rdata_d = absel_q;
				pioci_pkg::OFF_DIRECT_WRITE_STATUS: rdata_d = dwe_q;
				default: rdata_d = pioci_pkg::RST_ZERO;
			endcase
		end
	end

	// ==========================================
	// Change status: a change in the read cycle survives the clear
	always_comb begin
		isr_d = isr_q;
		if (reg_rd && reg_addr == pioci_pkg::OFF_CHANGE_IRQ_STATUS) begin
			isr_d = pioci_pkg::RST_ZERO;
		end
		isr_d = isr_d | change;
	end

	// ==========================================
	// Pin drive
	logic [31:0] out_d, oe_d, drv_lvl, drv_en;
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (own_q[i] || !MUXED_LINES[i]) begin
				drv_lvl[i] = lvl_q[i];
				drv_en[i] = drv_q[i];
			end else if (absel_q[i]) begin
				drv_lvl[i] = periph_b_out[i];
				drv_en[i] = periph_b_oe[i];
			end else begin
				drv_lvl[i] = periph_a_out[i];
				drv_en[i] = periph_a_oe[i];
			end
		end
		// Open drain only ever pulls low
		out_d = drv_lvl & ~od_q;
		oe_d = drv_en & ~(od_q & drv_lvl) & IMPL_LINES;
	end

	logic irq_q;
	logic [31:0] out_q, oe_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			own_q <= LINE_CTRL_RESET & IMPL_LINES;
			pull_q <= IMPL_LINES;
			drv_q <= pioci_pkg::RST_ZERO;
			filt_q <= pioci_pkg::RST_ZERO;
			lvl_q <= pioci_pkg::RST_ZERO;
			mask_q <= pioci_pkg::RST_ZERO;
			isr_q <= pioci_pkg::RST_ZERO;
			od_q <= pioci_pkg::RST_ZERO;
			pud_q <= pioci_pkg::RST_ZERO;
			absel_q <= pioci_pkg::RST_ZERO;
			dwe_q <= pioci_pkg::RST_ZERO;
			rdata_q <= pioci_pkg::RST_ZERO;
			irq_q <= 1'b0;
			out_q <= pioci_pkg::RST_ZERO;
			oe_q <= pioci_pkg::RST_ZERO;
		end else begin
			own_q <= own_d;
			// Registered so the pad pull-ups never see a decode glitch
			pull_q <= ~pud_d & IMPL_LINES;
			drv_q <= drv_d;
			filt_q <= filt_d;
			lvl_q <= lvl_d;
			mask_q <= mask_d;
			isr_q <= isr_d;
			od_q <= od_d;
			pud_q <= pud_d;
			absel_q <= absel_d;
			dwe_q <= dwe_d;
			rdata_q <= rdata_d;
			irq_q <= |(isr_d & mask_d);
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign change_irq = irq_q;
	assign pad_out = out_q;
	assign pad_oe = oe_q;
	assign pullup_on = pull_q;
	assign periph_in = sync2_q;

	// ==========================================
	// Checks
	a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##1 (change_irq == |($past(isr_d) & $past(mask_d))))
		else $error("irq mismatch");
	a_isr_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == pioci_pkg::OFF_CHANGE_IRQ_STATUS
		|=> isr_q == $past(change))
		else $error("status not cleared");
	a_change_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(change != 0) |=> ((isr_q & $past(change)) == $past(change)))
		else $error("change lost");
	a_mask_en: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_CHANGE_IRQ_ENABLE
		|=> (mask_q & $past(wmask)) == $past(wmask))
		else $error("mask not set");
	a_mask_dis: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_CHANGE_IRQ_DISABLE
		|=> (mask_q & $past(wmask)) == 0)
		else $error("mask not cleared");
	a_direct_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_OUT_LEVEL_STATUS
		|=> ((lvl_q ^ $past(lvl_q)) & ~$past(dwe_q)) == 0)
		else $error("locked bit written");
	a_ab_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_PERIPH_B_SELECT
		|=> (absel_q & $past(wmask)) == $past(wmask))
		else $error("b select lost");
	a_reserved_rd: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == 8'h0c |=> reg_rdata == 0)
		else $error("reserved not zero");
	a_psr_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == pioci_pkg::OFF_LINE_CTRL_STATUS
		|=> ((~reg_rdata) & ~MUXED_LINES & IMPL_LINES) == 0)
		else $error("unmuxed line not owned");
	a_isr_reset: assert property (@(posedge sys_clk)
		!rst_n |=> isr_q == pioci_pkg::RST_ZERO)
		else $error("status not zero after reset");
	a_pullup_reset: assert property (@(posedge sys_clk)
		!rst_n |=> pullup_on == IMPL_LINES)
		else $error("pullups off after reset");
	a_own_reset: assert property (@(posedge sys_clk)
		!rst_n |=> own_q == (LINE_CTRL_RESET & IMPL_LINES))
		else $error("ownership reset wrong");
	a_irq_reset: assert property (@(posedge sys_clk)
		!rst_n |=> !change_irq && mask_q == pioci_pkg::RST_ZERO)
		else $error("irq active after reset");
	a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
		change_irq == |(isr_q & mask_q))
		else $error("irq not status and mask");
	a_status_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
		change == 0 && !(reg_rd && reg_addr == pioci_pkg::OFF_CHANGE_IRQ_STATUS)
		|=> isr_q == $past(isr_q))
		else $error("status moved without cause");
	a_unimpl_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(reg_rdata & ~IMPL_LINES) == 32'h0000_0000)
		else $error("unimplemented bit read one");
	a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == pioci_pkg::RST_ZERO)
		else $error("read data without read");
	a_pin_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == pioci_pkg::OFF_PIN_LEVEL_STATUS
		|=> reg_rdata == ($past(pin_q) & IMPL_LINES))
		else $error("pin level readback wrong");
	a_a_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_PERIPH_A_SELECT
		|=> (absel_q & $past(wmask)) == 32'h0000_0000)
		else $error("a select lost");
	a_ow_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_DIRECT_WRITE_ENABLE
		|=> (dwe_q & $past(wmask)) == $past(wmask))
		else $error("direct write mask not set");
	a_dwrite_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_OUT_LEVEL_STATUS
		|=> ((lvl_q ^ $past(reg_wdata)) & $past(dwe_q) & IMPL_LINES) == 32'h0000_0000)
		else $error("direct write missed");
	a_unmux_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_LINE_CTRL_DISABLE
		|=> ((own_q ^ $past(own_q)) & ~MUXED_LINES) == 32'h0000_0000)
		else $error("unmuxed line released");
	a_filter_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> ((pin_q ^ $past(pin_q)) & $past(filt_q)
		& ($past(sync2_q) ^ $past(samp_q))) == 32'h0000_0000)
		else $error("filtered glitch passed");
	a_od_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> (pad_out & $past(od_q)) == 32'h0000_0000)
		else $error("open drain driven high");
	a_drv_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_DRIVE_ENABLE
		|=> (drv_q & $past(wmask)) == $past(wmask))
		else $error("drive not enabled");
	a_drv_disable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_DRIVE_DISABLE
		|=> (drv_q & $past(wmask)) == 32'h0000_0000)
		else $error("drive not disabled");
	a_filt_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_GLITCH_FILTER_ENABLE
		|=> (filt_q & $past(wmask)) == $past(wmask))
		else $error("filter not enabled");
	a_filt_disable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_GLITCH_FILTER_DISABLE
		|=> (filt_q & $past(wmask)) == 32'h0000_0000)
		else $error("filter not disabled");
	a_pull_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pioci_pkg::OFF_PULLUP_DISABLE
		|=> (pullup_on & $past(wmask)) == 32'h0000_0000)
		else $error("pullup not disabled");
	// ==========================================
	// Scenario covers
	c_filter: cover property (@(posedge sys_clk) (filt_q & (sync2_q ^ samp_q)) != 0);
	c_bsel: cover property (@(posedge sys_clk)
		reg_wr && reg_addr == pioci_pkg::OFF_PERIPH_B_SELECT);
	c_irq: cover property (@(posedge sys_clk) change_irq);
	c_clear: cover property (@(posedge sys_clk)
		reg_rd && reg_addr == pioci_pkg::OFF_CHANGE_IRQ_STATUS && isr_q != 0);
	c_dwrite: cover property (@(posedge sys_clk)
		reg_wr && reg_addr == pioci_pkg::OFF_OUT_LEVEL_STATUS && dwe_q != 0);
endmodule : pioci_top

/* bench/pioci_pins.sv */
`timescale 1ns/1ps
// ==========================================
// Far side: external devices on the pads
module pioci_pins (
	input wire logic [31:0] ext_level,
	input wire logic [31:0] pad_out,
	input wire logic [31:0] pad_oe,
	output logic [31:0] pad_in
);
	// Pad shows the controller level where it drives, else the device level
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : pioci_pins

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] pa_out = 32'h0000_0000;
	logic [31:0] pa_oe = 32'h0000_0000;
	logic [31:0] pb_out = 32'h0000_0000;
	logic [31:0] pb_oe = 32'h0000_0000;
	logic [31:0] ext_level = 32'h0000_0000;
	logic [31:0] reg_rdata, pad_in, pad_out, pad_oe, pullup_on, periph_in;
	logic change_irq;
	integer fails = 0;
	integer tests_run = 0;
	integer seed = 55665;
	integer i;
	logic [31:0] rd_v, m_mask, m_ab, m_odsr, m_ow, v, chg;
	logic [7:0] zero_offs [10] = '{pioci_pkg::OFF_DRIVE_STATUS,
		pioci_pkg::OFF_GLITCH_FILTER_STATUS, pioci_pkg::OFF_CHANGE_IRQ_MASK,
		pioci_pkg::OFF_OPEN_DRAIN_STATUS, pioci_pkg::OFF_PULLUP_STATUS,
		pioci_pkg::OFF_PERIPH_SELECT_STATUS, pioci_pkg::OFF_DIRECT_WRITE_STATUS,
		8'h0c, 8'h7c, pioci_pkg::OFF_CHANGE_IRQ_ENABLE};

	always #10 sys_clk = ~sys_clk;

	pioci_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pad_in(pad_in), .periph_a_out(pa_out), .periph_a_oe(pa_oe),
		.periph_b_out(pb_out), .periph_b_oe(pb_oe), .pad_out(pad_out), .pad_oe(pad_oe),
		.pullup_on(pullup_on), .periph_in(periph_in), .change_irq(change_irq));

	pioci_pins pins_u (.ext_level(ext_level), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_in(pad_in));

	// ==========================================
	// Bus and check tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask : rd

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	// ==========================================
	// Main sequence
	initial begin
		pa_out <= $random(seed);
		pa_oe <= $random(seed);
		pb_out <= $random(seed);
		pb_oe <= $random(seed);
		ext_level <= $random(seed);
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		for (i = 0; i < 10; i++) begin
			rd(zero_offs[i]);
			chk(rd_v, pioci_pkg::RST_ZERO);
		end
		rd(pioci_pkg::OFF_LINE_CTRL_STATUS);
		chk(rd_v, pioci_pkg::RST_LINE_CTRL_DEFAULT);
		chk(pullup_on, 32'hFFFF_FFFF);
		rd(pioci_pkg::OFF_CHANGE_IRQ_STATUS);
		chk(rd_v, pioci_pkg::RST_ZERO);
		$display("Reset values done");
		v = $random(seed);
		wr(pioci_pkg::OFF_CHANGE_IRQ_ENABLE, v);
		m_mask = v;
		v = $random(seed);
		wr(pioci_pkg::OFF_CHANGE_IRQ_DISABLE, v);
		m_mask = m_mask & ~v;
		rd(pioci_pkg::OFF_CHANGE_IRQ_MASK);
		chk(rd_v, m_mask);
		// First pass flips only lines with mask bit clear: status without interrupt
		for (i = 0; i < 4; i++) begin
			v = $random(seed);
			chg = (i == 0) ? (v & ~m_mask) : v;
			@(posedge sys_clk);
			ext_level <= ext_level ^ chg;
			repeat (8) @(posedge sys_clk);
			#1 chk({31'h0, change_irq}, {31'h0, |(chg & m_mask)});
			rd(pioci_pkg::OFF_PIN_LEVEL_STATUS);
			chk(rd_v, ext_level);
			rd(pioci_pkg::OFF_CHANGE_IRQ_STATUS);
			chk(rd_v, chg);
			repeat (2) @(posedge sys_clk);
			#1 chk({31'h0, change_irq}, 32'h0000_0000);
			rd(pioci_pkg::OFF_CHANGE_IRQ_STATUS);
			chk(rd_v, pioci_pkg::RST_ZERO);
		end
		$display("Change detection done");
		rd(pioci_pkg::OFF_OUT_LEVEL_STATUS);
		m_odsr = rd_v;
		m_ow = $random(seed);
		wr(pioci_pkg::OFF_DIRECT_WRITE_ENABLE, m_ow);
		rd(pioci_pkg::OFF_DIRECT_WRITE_STATUS);
		chk(rd_v, m_ow);
		v = $random(seed);
		wr(pioci_pkg::OFF_OUT_LEVEL_SET, v);
		m_odsr = m_odsr | v;
		v = $random(seed);
		wr(pioci_pkg::OFF_OUT_LEVEL_CLEAR, v);
		m_odsr = m_odsr & ~v;
		v = $random(seed);
		wr(pioci_pkg::OFF_OUT_LEVEL_STATUS, v);
		m_odsr = (m_odsr & ~m_ow) | (v & m_ow);
		rd(pioci_pkg::OFF_OUT_LEVEL_STATUS);
		chk(rd_v, m_odsr);
		wr(pioci_pkg::OFF_DRIVE_ENABLE, 32'hFFFF_FFFF);
		repeat (6) @(posedge sys_clk);
		#1 chk(pad_oe, 32'hFFFF_FFFF);
		chk(pad_out, m_odsr);
		chk(periph_in, m_odsr);
		rd(pioci_pkg::OFF_PIN_LEVEL_STATUS);
		chk(rd_v, m_odsr);
		$display("Direct write done");
		m_ab = 32'h0000_0000;
		for (i = 0; i < 3; i++) begin
			v = $random(seed);
			wr(pioci_pkg::OFF_PERIPH_B_SELECT, v);
			m_ab = m_ab | v;
			v = $random(seed);
			wr(pioci_pkg::OFF_PERIPH_A_SELECT, v);
			m_ab = m_ab & ~v;
			rd(pioci_pkg::OFF_PERIPH_SELECT_STATUS);
			chk(rd_v, m_ab);
		end
		$display("Peripheral select done");
		complete_run();
	end
endmodule : tb_top
